// *** src/fbdma_top.sv ***
// frame dma, read variant: register port, row fetch engine and stream output
`timescale 1ns/1ps
`include "fbdma_map.svh"
module fbdma_top
    import fbdma_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port, axi4-lite slave
    input wire logic [17:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [17:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // memory row read requests
    output logic mem_req_valid,
    input wire logic mem_req_ready,
    output fbdma_mem_req_t mem_req,
    // memory read data, 64 bits holding two 32-bit pixels, sent out over two stream beats
    input wire logic mem_rd_valid,
    output logic mem_rd_ready,
    input wire logic [63:0] mem_rd_data,
    // video stream out
    output logic [31:0] vid_tdata,
    output logic vid_tvalid,
    input wire logic vid_tready,
    output logic vid_tuser,
    output logic vid_tlast,
    // status
    output logic irq,
    output logic field_parity
);
    fbdma_regs_t q;
    fbdma_regs_t d;
    logic wr_go;
    logic rd_go;
    logic req_go;
    logic rd_acc;
    logic px_go;
    logic start_go;
    logic done_evt;
    logic ready_evt;
    logic [29:0] comp;

    // current readback of one register
    function automatic logic [31:0] reg_value(input logic [17:0] a, input fbdma_regs_t r);
        logic [31:0] v;
        v = `FBDMA_REG_RESET;
        if (a == `FBDMA_OFS_CTRL)
            v = {24'h000000, r.auto_restart, r.flush_done, r.flush, 1'b0,
                 (r.st == ST_IDLE) && !r.start, r.st == ST_IDLE, r.done, r.start};
        else if (a == `FBDMA_OFS_GIE)
            v = {31'h00000000, r.gie};
        else if (a == `FBDMA_OFS_IER)
            v = {30'h00000000, r.ier};
        else if (a == `FBDMA_OFS_ISR)
            v = {30'h00000000, r.isr};
        else if (a == `FBDMA_OFS_WIDTH)
            v = {16'h0000, r.width};
        else if (a == `FBDMA_OFS_HEIGHT)
            v = {16'h0000, r.height};
        else if (a == `FBDMA_OFS_STRIDE)
            v = r.stride;
        else if (a == `FBDMA_OFS_FMT)
            v = {26'h0000000, r.fmt};
        else if (a == `FBDMA_OFS_PLANE1)
            v = r.p1;
        else if (a == `FBDMA_OFS_PLANE2)
            v = r.p2;
        else if (a == `FBDMA_OFS_FIELD)
            v = {31'h00000000, r.fid};
        return v;
    endfunction

    // true for the eleven mapped word addresses
    function automatic logic reg_mapped(input logic [17:0] a);
        return a == `FBDMA_OFS_CTRL || a == `FBDMA_OFS_GIE || a == `FBDMA_OFS_IER ||
               a == `FBDMA_OFS_ISR || a == `FBDMA_OFS_WIDTH || a == `FBDMA_OFS_HEIGHT ||
               a == `FBDMA_OFS_STRIDE || a == `FBDMA_OFS_FMT || a == `FBDMA_OFS_PLANE1 ||
               a == `FBDMA_OFS_PLANE2 || a == `FBDMA_OFS_FIELD;
    endfunction

    // byte-lane merge of a write into the old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++)
            if (s[i])
                v[i*8 +: 8] = nw[i*8 +: 8];
        return v;
    endfunction

    function automatic logic is_10bit(input logic [5:0] f);
        return f[`FBDMA_FMT_BIT_10];
    endfunction

    function automatic logic is_semi(input logic [5:0] f);
        return f[`FBDMA_FMT_BIT_SEMI];
    endfunction

    // bus handshakes, one write and one read in flight
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !q.bvalid;
    assign rd_go = s_axi_arvalid && !q.rvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rdata = q.rdata;

    // engine handshakes; a held flush stops new requests and drains data
    assign start_go = q.st == ST_IDLE && q.start && !q.flush;
    assign mem_req_valid = q.st == ST_RUN && !q.reqs_done && !q.flush;
    assign mem_req.beats = {1'b0, q.width[15:1]};
    assign req_go = mem_req_valid && mem_req_ready;
    assign mem_rd_ready = !q.word_v || q.flush;
    assign rd_acc = mem_rd_valid && mem_rd_ready;
    assign vid_tvalid = q.st == ST_RUN && q.word_v && !q.flush;
    assign px_go = vid_tvalid && vid_tready;
    assign vid_tlast = q.col == q.width - 16'h0001;
    assign vid_tuser = q.col == 16'h0000 && q.orow == 16'h0000 && !q.opass;
    assign vid_tdata = {2'h0, comp};
    assign field_parity = q.fid;

    // master gate over the two enabled sources
    assign irq = q.gie && ((q.ier & q.isr) != 2'h0);

    fbdma_addr_gen u_addr (
        .plane_one(q.p1),
        .plane_two(q.p2),
        .stride(q.stride),
        .row(q.rrow),
        .use_plane_two(q.rpass),
        .addr(mem_req.addr)
    );

    fbdma_comp_scale u_scale (
        .pix(q.half ? q.word[63:32] : q.word[31:0]),
        .is_10bit(is_10bit(q.fmt)),
        .comp(comp)
    );

    // next state: register port, fetch side, stream side, events
    always_comb
    begin
        logic [31:0] cw;
        logic [15:0] oc;
        cw = merge(reg_value(s_axi_awaddr, q), s_axi_wdata, s_axi_wstrb);
        oc = q.outst;
        d = q;
        done_evt = 1'b0;
        ready_evt = 1'b0;
        if (q.bvalid && s_axi_bready)
            d.bvalid = 1'b0;
        if (wr_go)
        begin
            d.bvalid = 1'b1;
            d.bresp = reg_mapped(s_axi_awaddr) ? `FBDMA_RESP_OKAY : `FBDMA_RESP_SLVERR;
            if (s_axi_awaddr == `FBDMA_OFS_CTRL)
            begin
                if (cw[`FBDMA_CTRL_START])
                    d.start = 1'b1;
                d.flush = cw[`FBDMA_CTRL_FLUSH];
                d.auto_restart = cw[`FBDMA_CTRL_AUTO];
            end
            else if (s_axi_awaddr == `FBDMA_OFS_GIE)
                d.gie = cw[0];
            else if (s_axi_awaddr == `FBDMA_OFS_IER)
                d.ier = cw[1:0];
            else if (s_axi_awaddr == `FBDMA_OFS_ISR)
                d.isr = q.isr & ~(s_axi_wdata[1:0] & {2{s_axi_wstrb[0]}});
            else if (s_axi_awaddr == `FBDMA_OFS_WIDTH)
                d.width = cw[15:0];
            else if (s_axi_awaddr == `FBDMA_OFS_HEIGHT)
                d.height = cw[15:0];
            else if (s_axi_awaddr == `FBDMA_OFS_STRIDE)
                d.stride = cw;
            else if (s_axi_awaddr == `FBDMA_OFS_FMT)
                d.fmt = cw[5:0];
            else if (s_axi_awaddr == `FBDMA_OFS_PLANE1)
                d.p1 = cw;
            else if (s_axi_awaddr == `FBDMA_OFS_PLANE2)
                d.p2 = cw;
            else if (s_axi_awaddr == `FBDMA_OFS_FIELD)
                d.fid = cw[0];
        end
        if (q.rvalid && s_axi_rready)
            d.rvalid = 1'b0;
        if (rd_go)
        begin
            d.rvalid = 1'b1;
            d.rdata = reg_value(s_axi_araddr, q);
            d.rresp = reg_mapped(s_axi_araddr) ? `FBDMA_RESP_OKAY : `FBDMA_RESP_SLVERR;
            if (s_axi_araddr == `FBDMA_OFS_CTRL)
                d.done = 1'b0;
        end
        // row requests walk plane one, then plane two for semi-planar
        if (req_go)
        begin
            oc = oc + mem_req.beats;
            if (q.rrow == q.height - 16'h0001)
            begin
                d.rrow = 16'h0000;
                if (is_semi(q.fmt) && !q.rpass)
                    d.rpass = 1'b1;
                else
                    d.reqs_done = 1'b1;
            end
            else
                d.rrow = q.rrow + 16'h0001;
        end
        // returned words are held for two pixels, or dropped when flushing
        if (rd_acc)
        begin
            oc = oc - 16'h0001;
            if (!q.flush)
            begin
                d.word = mem_rd_data;
                d.word_v = 1'b1;
                d.half = 1'b0;
            end
        end
        d.outst = oc;
        d.flush_done = q.flush && oc == 16'h0000;
        // one pixel per stream beat, end of frame after the last pass
        if (px_go)
        begin
            if (!q.half)
                d.half = 1'b1;
            else
                d.word_v = 1'b0;
            if (vid_tlast)
            begin
                d.col = 16'h0000;
                if (q.orow == q.height - 16'h0001)
                begin
                    d.orow = 16'h0000;
                    if (is_semi(q.fmt) && !q.opass)
                        d.opass = 1'b1;
                    else
                    begin
                        d.st = ST_IDLE;
                        done_evt = 1'b1;
                    end
                end
                else
                    d.orow = q.orow + 16'h0001;
            end
            else
                d.col = q.col + 16'h0001;
        end
        // start is taken here and frees the start bit for the next frame
        if (start_go)
        begin
            d.st = ST_RUN;
            d.start = 1'b0;
            d.rrow = 16'h0000;
            d.rpass = 1'b0;
            d.reqs_done = 1'b0;
            d.col = 16'h0000;
            d.orow = 16'h0000;
            d.opass = 1'b0;
            d.word_v = 1'b0;
            ready_evt = 1'b1;
        end
        // events are applied last so a set beats a same-cycle clear
        if (done_evt)
        begin
            d.done = 1'b1;
            d.isr[`FBDMA_ISR_DONE] = 1'b1;
            if (q.auto_restart)
                d.start = 1'b1;
        end
        if (ready_evt)
            d.isr[`FBDMA_ISR_READY] = 1'b1;
    end

    // state register
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            q <= '0;
        else
            q <= d;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_irq_gate_off: assert property (!q.gie |-> !irq)
        else $error("interrupt raised with global enable clear");
    chk_irq_has_source: assert property (irq |-> (q.ier & q.isr) != 2'h0 && q.gie)
        else $error("interrupt without an enabled pending source");
    chk_start_taken: assert property (start_go |=> q.st == ST_RUN && !q.start && q.isr[1])
        else $error("start not taken or ready not flagged");
    chk_done_flags: assert property (done_evt |=> q.done && q.isr[0] && q.st == ST_IDLE)
        else $error("frame end did not flag completion");
    chk_done_clear_read: assert property (rd_go && s_axi_araddr == `FBDMA_OFS_CTRL && !done_evt |=> !q.done)
        else $error("done not cleared by control read");
    chk_status_w1c: assert property (wr_go && s_axi_awaddr == `FBDMA_OFS_ISR && s_axi_wstrb[0] && s_axi_wdata[0]
                                     && !done_evt |=> !q.isr[0])
        else $error("status bit survived a clearing write");
    chk_flush_drained: assert property (q.flush && q.outst == 16'h0000 && !rd_acc |=> q.flush_done)
        else $error("flush done missing after drain");
    chk_row_address: assert property (mem_req_valid |-> mem_req.addr ==
                                      (q.rpass ? q.p2 : q.p1) + 32'(q.rrow * q.stride))
        else $error("row address not base plus row times stride");
    chk_widen_pad: assert property (vid_tvalid && !is_10bit(q.fmt) |-> vid_tdata[1:0] == 2'h0
                                    && vid_tdata[11:10] == 2'h0 && vid_tdata[21:20] == 2'h0)
        else $error("8-bit component not shifted by two");
    chk_reserved_zero: assert property (rd_go && s_axi_araddr == `FBDMA_OFS_CTRL |=> q.rdata[31:8] == 24'h0
                                        && !q.rdata[4])
        else $error("reserved control bits read nonzero");
    chk_auto_restart: assert property (done_evt && q.auto_restart |=> q.start)
        else $error("auto-restart did not rearm the start bit");

    cov_frame_done: cover property (done_evt);
    cov_auto_restart: cover property (done_evt && q.auto_restart ##1 start_go);
    cov_flush_done: cover property ($rose(q.flush_done));
    cov_chroma_pass: cover property (px_go && q.opass);
endmodule // fbdma_top

// *** src/fbdma_map.svh ***
// register offsets, field positions, codes and reset values of the frame dma
`ifndef FBDMA_MAP_SVH
`define FBDMA_MAP_SVH
`define FBDMA_OFS_CTRL 18'h00000
`define FBDMA_OFS_GIE 18'h00004
`define FBDMA_OFS_IER 18'h00008
`define FBDMA_OFS_ISR 18'h0000c
`define FBDMA_OFS_WIDTH 18'h00010
`define FBDMA_OFS_HEIGHT 18'h00018
`define FBDMA_OFS_STRIDE 18'h00020
`define FBDMA_OFS_FMT 18'h00028
`define FBDMA_OFS_PLANE1 18'h00030
`define FBDMA_OFS_PLANE2 18'h0003c
`define FBDMA_OFS_FIELD 18'h00048
`define FBDMA_CTRL_START 0
`define FBDMA_CTRL_DONE 1
`define FBDMA_CTRL_IDLE 2
`define FBDMA_CTRL_READY 3
`define FBDMA_CTRL_FLUSH 5
`define FBDMA_CTRL_FLUSH_DONE 6
`define FBDMA_CTRL_AUTO 7
`define FBDMA_ISR_DONE 0
`define FBDMA_ISR_READY 1
`define FBDMA_FMT_BIT_10 0
`define FBDMA_FMT_BIT_SEMI 1
`define FBDMA_RESP_OKAY 2'h0
`define FBDMA_RESP_SLVERR 2'h2
`define FBDMA_SCALE_PAD 2'h0
`define FBDMA_REG_RESET 32'h00000000
`endif

// *** src/fbdma_pkg.sv ***
// types shared by the frame dma modules
package fbdma_pkg;
    typedef enum logic [0:0] {ST_IDLE, ST_RUN} fbdma_state_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [15:0] beats;
    } fbdma_mem_req_t;

    typedef struct packed {
        fbdma_state_t st;
        logic start;
        logic done;
        logic auto_restart;
        logic flush;
        logic flush_done;
        logic gie;
        logic [1:0] ier;
        logic [1:0] isr;
        logic [15:0] width;
        logic [15:0] height;
        logic [31:0] stride;
        logic [5:0] fmt;
        logic [31:0] p1;
        logic [31:0] p2;
        logic fid;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [15:0] rrow;
        logic rpass;
        logic reqs_done;
        logic [15:0] col;
        logic [15:0] orow;
        logic opass;
        logic [63:0] word;
        logic word_v;
        logic half;
        logic [15:0] outst;
    } fbdma_regs_t;
endpackage

// *** src/fbdma_addr_gen.sv ***
// row start address from plane base, stride and row index
`timescale 1ns/1ps
module fbdma_addr_gen
    import fbdma_pkg::*;
(
    // plane bases and geometry
    input wire logic [31:0] plane_one,
    input wire logic [31:0] plane_two,
    input wire logic [31:0] stride,
    input wire logic [15:0] row,
    input wire logic use_plane_two,
    // row address
    output logic [31:0] addr
);
    logic [47:0] offset;

    // stride spaces rows, padding is skipped by the row beat count
    assign offset = 48'(row) * 48'(stride);
    assign addr = (use_plane_two ? plane_two : plane_one) + offset[31:0];
endmodule // fbdma_addr_gen

// *** src/fbdma_comp_scale.sv ***
// unpacks one memory pixel into three 10-bit stream components
`timescale 1ns/1ps
`include "fbdma_map.svh"
module fbdma_comp_scale
    import fbdma_pkg::*;
(
    // memory pixel
    input wire logic [31:0] pix,
    input wire logic is_10bit,
    // stream components
    output logic [29:0] comp
);
    // 8-bit components are widened by a two-place left shift
    for (genvar i = 0; i < 3; i++)
    begin : g_comp
        assign comp[i*10 +: 10] = is_10bit ? pix[i*10 +: 10] : {pix[i*8 +: 8], `FBDMA_SCALE_PAD};
    end
endmodule // fbdma_comp_scale

// *** bench/fbdma_mem_model.sv ***
// memory partner: takes row requests and returns their 64-bit words, prompt or slow
`timescale 1ns/1ps
module fbdma_mem_model
    import fbdma_pkg::*;
(
    // clock, reset and pace
    input wire logic clk,
    input wire logic reset,
    input wire logic slow,
    // row requests
    input wire logic req_valid,
    output logic req_ready,
    input wire fbdma_mem_req_t req,
    // read data
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [63:0] rd_data
);
    fbdma_mem_req_t q[$];
    int beat;
    int pseed = 32'h5304;
    logic [31:0] a;

    // pixel stored at a byte address
    function automatic logic [31:0] px(input logic [31:0] x);
        return {~x[15:0], x[15:0]};
    endfunction

    // queue requests, send the oldest row word by word, scramble idle data
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            q.delete();
            beat = 0;
            req_ready <= 1'h0;
            rd_valid <= 1'h0;
            rd_data <= 64'h0;
        end
        else
        begin
            if (req_valid && req_ready)
                q.push_back(req);
            req_ready <= slow ? 1'($random(pseed)) : 1'h1;
            if (!rd_valid || rd_ready)
            begin
                if (q.size() != 0 && (!slow || $random(pseed) % 3 != 0))
                begin
                    a = q[0].addr + 32'(beat) * 32'h8;
                    rd_data <= {px(a + 32'h4), px(a)};
                    rd_valid <= 1'h1;
                    beat++;
                    if (beat >= int'(q[0].beats))
                    begin
                        beat = 0;
                        void'(q.pop_front());
                    end
                end
                else
                begin
                    rd_valid <= 1'h0;
                    rd_data <= ~rd_data;
                end
            end
        end
    end
endmodule // fbdma_mem_model

// *** bench/testbench.sv ***
// self-checking bench: register tasks, frame model, stream and request monitors
`timescale 1ns/1ps
`include "fbdma_map.svh"
module testbench
    import fbdma_pkg::*;
;
    logic clk = 1'h0, reset = 1'h1, slow = 1'h0, flushing = 1'h0;
    logic [17:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = '0, v, d;
    logic [1:0] r;
    logic vid_tready = 1'h0;
    logic [3:0] wstrb = 4'hf;
    wire awready, wready, bvalid, arready, rvalid, mem_req_valid, mem_req_ready;
    wire mem_rd_valid, mem_rd_ready, vid_tvalid, vid_tuser, vid_tlast, irq, field_parity;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata, vid_tdata;
    wire [63:0] mem_rd_data;
    fbdma_mem_req_t mem_req;
    fbdma_mem_req_t rq_q[$];
    logic [33:0] px_q[$];
    int errors = 0, tests_run = 0, seed = 32'h5304, n;
    logic [17:0] rw_ofs [9] = '{`FBDMA_OFS_GIE, `FBDMA_OFS_IER, `FBDMA_OFS_WIDTH, `FBDMA_OFS_HEIGHT,
        `FBDMA_OFS_STRIDE, `FBDMA_OFS_FMT, `FBDMA_OFS_PLANE1, `FBDMA_OFS_PLANE2, `FBDMA_OFS_FIELD};
    logic [31:0] rw_msk [9] = '{32'h1, 32'h3, 32'hffff, 32'hffff, '1, 32'h3f, '1, '1, 32'h1};

    fbdma_top uut (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready),
        .mem_req(mem_req), .mem_rd_valid(mem_rd_valid), .mem_rd_ready(mem_rd_ready),
        .mem_rd_data(mem_rd_data), .vid_tdata(vid_tdata), .vid_tvalid(vid_tvalid),
        .vid_tready(vid_tready), .vid_tuser(vid_tuser), .vid_tlast(vid_tlast), .irq(irq),
        .field_parity(field_parity));
    fbdma_mem_model mem (.clk(clk), .reset(reset), .slow(slow), .req_valid(mem_req_valid),
        .req_ready(mem_req_ready), .req(mem_req), .rd_valid(mem_rd_valid), .rd_ready(mem_rd_ready),
        .rd_data(mem_rd_data));

    // clock
    always #4 clk = ~clk;

    // stream sink pace
    always @(posedge clk)
        vid_tready <= slow ? 1'($random(seed)) : 1'h1;

    // compare every request and every pixel outside the flush with the frame model
    always @(posedge clk)
    begin
        if (!reset && !flushing && mem_req_valid === 1'h1 && mem_req_ready)
            check(mem_req, rq_q.size() ? rq_q.pop_front() : '0, "request");
        if (!reset && !flushing && vid_tvalid === 1'h1 && vid_tready)
            check({vid_tuser, vid_tlast, vid_tdata}, px_q.size() ? px_q.pop_front() : '0, "pixel");
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // register write, request held until the taking edge
    task automatic wr(input logic [17:0] a, input logic [31:0] dv, input logic [1:0] er);
        int k;
        @(posedge clk);
        awaddr <= a;
        wdata <= dv;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        k = 0;
        do @(negedge clk); while (awready !== 1'h1 && ++k < 50);
        @(posedge clk);
        awvalid <= 1'h0;
        wvalid <= 1'h0;
        do @(negedge clk); while (bvalid !== 1'h1 && ++k < 50);
        check({k >= 50, bresp}, {1'b0, er}, "write response");
        @(posedge clk);
        bready <= 1'h0;
    endtask

    // register read
    task automatic rd(input logic [17:0] a, output logic [31:0] dv, output logic [1:0] rv);
        int k;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        k = 0;
        do @(negedge clk); while (arready !== 1'h1 && ++k < 50);
        @(posedge clk);
        arvalid <= 1'h0;
        do @(negedge clk); while (rvalid !== 1'h1 && ++k < 50);
        dv = rdata;
        rv = k >= 50 ? 2'h3 : rresp; // a stalled bus reads as an error
        @(posedge clk);
        rready <= 1'h0;
    endtask

    // read, mask and compare
    task automatic rc(input logic [17:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] dv;
        logic [1:0] rv;
        rd(a, dv, rv);
        check({rv, dv & m}, {2'h0, e}, "register");
    endtask

    task automatic irqc(input logic e);
        @(negedge clk);
        check(irq, e, "irq");
    endtask

    // build the expected rows and pixels, program the geometry and write the control word
    task automatic frame(input logic semi, input logic ten, input int w, input int h,
        input logic [31:0] st, input logic [31:0] b1, input logic [31:0] b2, input logic [31:0] cv);
        logic [31:0] a, p;
        for (int ps = 0; ps <= int'(semi); ps++)
            for (int y = 0; y < h; y++)
            begin
                a = (ps != 0 ? b2 : b1) + st * 32'(y);
                rq_q.push_back('{a, 16'(w / 2)});
                for (int c = 0; c < w; c++)
                begin
                    p = a + 32'(4 * c);
                    p = {~p[15:0], p[15:0]};
                    px_q.push_back({ps == 0 && y == 0 && c == 0, c == w - 1, ten ? {2'h0, p[29:0]} :
                        {2'h0, p[23:16], 2'h0, p[15:8], 2'h0, p[7:0], 2'h0}});
                end
            end
        wr(`FBDMA_OFS_WIDTH, 32'(w), 2'h0);
        wr(`FBDMA_OFS_HEIGHT, 32'(h), 2'h0);
        wr(`FBDMA_OFS_STRIDE, st, 2'h0);
        wr(`FBDMA_OFS_FMT, {30'h0, semi, ten}, 2'h0);
        wr(`FBDMA_OFS_PLANE1, b1, 2'h0);
        wr(`FBDMA_OFS_PLANE2, b2, 2'h0);
        wr(`FBDMA_OFS_CTRL, cv, 2'h0);
    endtask

    task automatic drain();
        int k;
        k = 0;
        while (px_q.size() != 0 && k++ < 40000)
            @(posedge clk);
        repeat (4) @(posedge clk);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // watchdog
    initial
    begin
        #720000;
        errors++;
        $display("BAD %0t watchdog expired", $time);
        tally_and_finish();
    end

    // main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        reset <= 1'h0;
        rc(`FBDMA_OFS_CTRL, '1, 32'hc);
        rc(`FBDMA_OFS_ISR, '1, 32'h0);
        for (int i = 0; i < 9; i++)
            rc(rw_ofs[i], '1, 32'h0);
        for (int i = 0; i < 9; i++)
        begin
            v = $random(seed);
            wr(rw_ofs[i], v, 2'h0);
            rc(rw_ofs[i], '1, v & rw_msk[i]);
        end
        check(field_parity, v[0], "field");
        // byte strobes: only lane 1 of the second write lands
        wr(`FBDMA_OFS_STRIDE, 32'h12345678, 2'h0);
        wstrb <= 4'h2;
        wr(`FBDMA_OFS_STRIDE, 32'hffffffff, 2'h0);
        wstrb <= 4'hf;
        rc(`FBDMA_OFS_STRIDE, '1, 32'h1234ff78);
        wr(`FBDMA_OFS_CTRL, 32'hffffff10, 2'h0);
        rc(`FBDMA_OFS_CTRL, '1, 32'hc);
        wr(`FBDMA_OFS_CTRL, 32'h80, 2'h0);
        rc(`FBDMA_OFS_CTRL, '1, 32'h8c);
        wr(`FBDMA_OFS_CTRL, 32'h0, 2'h0);
        rd(18'h00100, d, r);
        check({r, d}, {2'h2, 32'h0}, "unmapped read");
        wr(18'h00104, 32'h1, 2'h2);
        $display("test registers done");
        wr(`FBDMA_OFS_GIE, 32'h1, 2'h0);
        wr(`FBDMA_OFS_IER, 32'h3, 2'h0);
        frame(1'h0, 1'h1, 64, 64, 32'h100, 32'h1000, 32'h0, 32'h1);
        drain();
        check(px_q.size() + rq_q.size(), 0, "frame length");
        rc(`FBDMA_OFS_ISR, '1, 32'h3);
        irqc(1'h1);
        rc(`FBDMA_OFS_CTRL, '1, 32'he);
        rc(`FBDMA_OFS_CTRL, '1, 32'hc);
        wr(`FBDMA_OFS_ISR, 32'h1, 2'h0);
        rc(`FBDMA_OFS_ISR, '1, 32'h2);
        wr(`FBDMA_OFS_IER, 32'h1, 2'h0);
        irqc(1'h0);
        wr(`FBDMA_OFS_IER, 32'h2, 2'h0);
        irqc(1'h1);
        wr(`FBDMA_OFS_GIE, 32'h0, 2'h0);
        irqc(1'h0);
        wr(`FBDMA_OFS_GIE, 32'h1, 2'h0);
        wr(`FBDMA_OFS_ISR, 32'h2, 2'h0);
        rc(`FBDMA_OFS_ISR, '1, 32'h0);
        irqc(1'h0);
        $display("test packed frame done");
        slow <= 1'h1;
        frame(1'h1, 1'h0, 64, 64, 32'h140, 32'h4000, 32'h10000, 32'h1);
        drain();
        check(px_q.size() + rq_q.size(), 0, "frame length");
        rc(`FBDMA_OFS_ISR, '1, 32'h3);
        $display("test semi-planar frame done");
        // first run with auto-restart; the second run is expected without a new start
        frame(1'h0, 1'h1, 64, 64, 32'h100, 32'h20000, 32'h0, 32'h81);
        frame(1'h0, 1'h1, 64, 64, 32'h100, 32'h20000, 32'h0, 32'h80);
        while (px_q.size() > 4000)
            @(posedge clk);
        @(negedge clk);
        flushing = 1'h1;
        wr(`FBDMA_OFS_CTRL, 32'h20, 2'h0);
        n = 0;
        do
        begin
            rd(`FBDMA_OFS_CTRL, d, r);
            n++;
        end
        while (d[6] !== 1'h1 && n < 1500);
        check(d[6], 1'h1, "flush done");
        check(mem_req_valid, 1'h0, "requests during flush");
        @(posedge clk);
        reset <= 1'h1;
        repeat (4) @(posedge clk);
        reset <= 1'h0;
        px_q.delete();
        rq_q.delete();
        rc(`FBDMA_OFS_CTRL, '1, 32'hc);
        $display("test flush done");
        tally_and_finish();
    end
endmodule // testbench
